//--- rtl/mbrf_defines.svh
// constants for the mode-banked register file
// assumes inclusion by bare name from every design file that needs them
`ifndef MBRF_DEFINES_SVH
`define MBRF_DEFINES_SVH
// physical storage: 15 shared, 7 fast, 2 interrupt, 2 supervisor
`define MBRF_NPHYS 26
// architectural register numbers
`define MBRF_IDX_R8 4'h8
`define MBRF_IDX_R13 4'hD
`define MBRF_IDX_R14 4'hE
`define MBRF_IDX_R15 4'hF
// physical slots of banked registers
`define MBRF_FIQ_OFS 5'h07
`define MBRF_PH_IRQ13 5'h16
`define MBRF_PH_IRQ14 5'h17
`define MBRF_PH_SVC13 5'h18
`define MBRF_PH_SVC14 5'h19
// status byte layout: n z c v i f m1 m0
`define MBRF_ST_FLAGS 7:4
`define MBRF_ST_I 3
`define MBRF_ST_F 2
`define MBRF_ST_MODE 1:0
`define MBRF_ST_CTL 3:0
// combined word layout
`define MBRF_WD_STHI 31:26
`define MBRF_WD_PC 25:2
`define MBRF_WD_STLO 1:0
// reset and fill values
`define MBRF_PC_RST 24'h000000
`define MBRF_ST_ZERO 8'h00
// reset status: flags clear, both masks set, supervisor mode
`define MBRF_ST_RST 8'h0F
`define MBRF_WORD_ZERO 32'h00000000
`define MBRF_ALIGN_ZERO 2'h0
`define MBRF_BIT_SET 1'h1
`endif

//--- rtl/mbrf_pkg.sv
// types shared by the mode-banked register file
// assumes nothing beyond a SystemVerilog compiler
package mbrf_pkg;
  // operating modes, held in the low two status bits
  typedef enum logic [1:0] {
    MBRF_USR = 2'b00,
    MBRF_FIQ = 2'b01,
    MBRF_IRQ = 2'b10,
    MBRF_SVC = 2'b11
  } mbrf_mode_e;
  // exception causes presented by the core
  typedef enum logic [2:0] {
    MBRF_EXC_FIQ = 3'b000,
    MBRF_EXC_IRQ = 3'b001,
    MBRF_EXC_SWI = 3'b010,
    MBRF_EXC_PABT = 3'b011,
    MBRF_EXC_DABT = 3'b100,
    MBRF_EXC_UND = 3'b101
  } mbrf_exc_e;
endpackage : mbrf_pkg

//--- rtl/mbrf_bank_sel.sv
// maps a register number and mode onto a physical storage slot
// assumes index 15 is handled by the caller; it maps to slot 15, the fast-mode register 8 slot
`include "mbrf_defines.svh"
module mbrf_bank_sel (
  // mode and architectural number
  input wire mbrf_pkg::mbrf_mode_e i_mode,
  input wire logic [3:0] i_idx,
  // physical slot
  output logic [4:0] o_phys
);
  // register number widened to slot width
  wire logic [4:0] idx_w = {1'h0, i_idx};
  // fast mode banks 8..14
  wire logic fiq_hit = (i_mode == mbrf_pkg::MBRF_FIQ) &&
                       (i_idx >= `MBRF_IDX_R8) && (i_idx <= `MBRF_IDX_R14);
  // interrupt and supervisor modes bank 13 and 14
  wire logic r13 = (i_idx == `MBRF_IDX_R13);
  wire logic r14 = (i_idx == `MBRF_IDX_R14);
  wire logic irq_hit = (i_mode == mbrf_pkg::MBRF_IRQ) && (r13 || r14);
  wire logic svc_hit = (i_mode == mbrf_pkg::MBRF_SVC) && (r13 || r14);
  // slot choice; everything else stays shared
  assign o_phys = fiq_hit ? idx_w + `MBRF_FIQ_OFS :
                  irq_hit ? (r13 ? `MBRF_PH_IRQ13 : `MBRF_PH_IRQ14) :
                  svc_hit ? (r13 ? `MBRF_PH_SVC13 : `MBRF_PH_SVC14) :
                  idx_w;
endmodule // mbrf_bank_sel

//--- rtl/mbrf_regfile.sv
// mode-banked register file with combined counter and status register
// assumes the core pipeline drives all requests synchronous to i_sys_clk
// and that reads are wanted one cycle after the index is presented
`include "mbrf_defines.svh"

// How it works
// - four modes; all but application privileged
// - aborts and undefined instructions enter supervisor
// - sixteen 32-bit registers visible, shared in application
// - interrupt and supervisor bank registers 13, 14
// - fast interrupt mode banks registers 8 to 14
// - register 15 is 24-bit counter plus status
// - fetch address is counter with two zeros
// - program counter always a word multiple
// - condition flags writable in every mode
// - masks and mode written only when privileged or on exception entry
// - branch-with-link copies counter and status to 14
// - exception entry saves register 15 into banked 14
// - status-write compare writes status, adopting new mode
// - register 15 as first operand hides status
// - mode field 2 interrupt, 0 application
// - application mode ignores mode field writes
// - application left only by exception entry: interrupt, trap, abort or undefined
module mbrf_regfile (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // operand reads, data one cycle later
  input wire logic [3:0] i_rd_a_idx,
  input wire logic [3:0] i_rd_b_idx,
  // general write port
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_idx,
  input wire logic [31:0] i_wr_data,
  // counter update from the pipeline
  input wire logic i_pc_wr,
  input wire logic [23:0] i_pc_data,
  // condition flag update
  input wire logic i_flags_wr,
  input wire logic [3:0] i_flags,
  // status-write compare result
  input wire logic i_stat_wr,
  input wire logic [31:0] i_stat_data,
  // branch-with-link
  input wire logic i_link_wr,
  input wire logic [23:0] i_link_pc,
  // exception request
  input wire logic i_exc_req,
  input wire mbrf_pkg::mbrf_exc_e i_exc_kind,
  input wire logic [23:0] i_exc_vec,
  // operand data
  output logic [31:0] o_rd_a_data,
  output logic [31:0] o_rd_b_data,
  // core state
  output logic [25:0] o_fetch_addr,
  output logic [7:0] o_status,
  output logic [1:0] o_mode,
  output logic o_exc_taken
);

  // packs counter and status into the combined word
  function automatic logic [31:0] pack_word(input logic [7:0] st,
                                            input logic [23:0] cnt);
    logic [31:0] w;
    w = `MBRF_WORD_ZERO;
    w[`MBRF_WD_STHI] = st[7:2];
    w[`MBRF_WD_PC] = cnt;
    w[`MBRF_WD_STLO] = st[`MBRF_ST_MODE];
    return w;
  endfunction

  // pulls the status byte out of a combined word
  function automatic logic [7:0] word_status(input logic [31:0] w);
    return {w[`MBRF_WD_STHI], w[`MBRF_WD_STLO]};
  endfunction

  // storage
  logic [31:0] regs [`MBRF_NPHYS]; // banked general registers
  logic [23:0] program_counter; // word counter
  logic [7:0] processor_status_bits; // flags, masks, mode

  // current mode decoded from the status byte
  wire mbrf_pkg::mbrf_mode_e mode =
    mbrf_pkg::mbrf_mode_e'(processor_status_bits[`MBRF_ST_MODE]);
  // every mode except application is privileged
  wire logic privileged = (mode != mbrf_pkg::MBRF_USR);

  // combined register value
  wire logic [31:0] combined_counter_status_register =
    pack_word(processor_status_bits, program_counter);

  // exception acceptance: masked interrupts are ignored
  wire logic irq_kind = (i_exc_kind == mbrf_pkg::MBRF_EXC_IRQ);
  wire logic fiq_kind = (i_exc_kind == mbrf_pkg::MBRF_EXC_FIQ);
  wire logic i_mask = processor_status_bits[`MBRF_ST_I];
  wire logic f_mask = processor_status_bits[`MBRF_ST_F];
  wire logic exc_go = i_exc_req && !(irq_kind && i_mask) &&
                      !(fiq_kind && f_mask);

  // target mode; aborts, undefined and traps go supervisor
  wire mbrf_pkg::mbrf_mode_e tgt_mode =
    fiq_kind ? mbrf_pkg::MBRF_FIQ :
    irq_kind ? mbrf_pkg::MBRF_IRQ :
    mbrf_pkg::MBRF_SVC;

  // physical slots for each access
  logic [4:0] ph_a; // first operand
  logic [4:0] ph_b; // second operand
  logic [4:0] ph_w; // write port
  logic [4:0] ph_l; // link in current mode
  logic [4:0] ph_x; // link in entered mode

  // operand a slot, current mode
  mbrf_bank_sel u_sel_a (
    .i_mode(mode),
    .i_idx(i_rd_a_idx),
    .o_phys(ph_a)
  );
  // operand b slot, current mode
  mbrf_bank_sel u_sel_b (
    .i_mode(mode),
    .i_idx(i_rd_b_idx),
    .o_phys(ph_b)
  );
  // write slot, current mode
  mbrf_bank_sel u_sel_w (
    .i_mode(mode),
    .i_idx(i_wr_idx),
    .o_phys(ph_w)
  );
  // link slot, current mode
  mbrf_bank_sel u_sel_l (
    .i_mode(mode),
    .i_idx(`MBRF_IDX_R14),
    .o_phys(ph_l)
  );
  // link slot of the mode being entered
  mbrf_bank_sel u_sel_x (
    .i_mode(tgt_mode),
    .i_idx(`MBRF_IDX_R14),
    .o_phys(ph_x)
  );

  // writes aimed at register 15 only move the counter
  wire logic wr_r15 = i_wr_en && (i_wr_idx == `MBRF_IDX_R15);
  wire logic wr_gen = i_wr_en && !wr_r15 && !exc_go;
  wire logic link_go = i_link_wr && !exc_go;

  // link value: return counter with present status
  wire logic [31:0] link_word =
    pack_word(processor_status_bits, i_link_pc);

  // status byte from a status-write compare
  wire logic [7:0] ws = word_status(i_stat_data);
  // user mode keeps masks and mode, flags always pass
  wire logic [7:0] stat_val = privileged ? ws :
    {ws[`MBRF_ST_FLAGS], processor_status_bits[`MBRF_ST_CTL]};

  // exception entry: set i, set f on fast interrupt, new mode
  wire logic [7:0] exc_st = {
    processor_status_bits[`MBRF_ST_FLAGS],
    `MBRF_BIT_SET,
    fiq_kind | f_mask,
    tgt_mode
  };

  // flag-only update keeps control bits
  wire logic [7:0] flag_st =
    {i_flags, processor_status_bits[`MBRF_ST_CTL]};

  // status priority: exception, status write, flags
  // only exceptions (interrupts, traps) can leave application mode
  wire logic [7:0] next_status =
    exc_go ? exc_st :
    i_stat_wr ? stat_val :
    i_flags_wr ? flag_st :
    processor_status_bits;

  // counter priority: exception vector, pipeline, write port
  wire logic [23:0] next_pc =
    exc_go ? i_exc_vec :
    i_pc_wr ? i_pc_data :
    wr_r15 ? i_wr_data[`MBRF_WD_PC] :
    program_counter;

  // operand a sees register 15 without status
  wire logic [31:0] next_rd_a = (i_rd_a_idx == `MBRF_IDX_R15) ?
    pack_word(`MBRF_ST_ZERO, program_counter) :
    regs[ph_a];
  // operand b sees the full combined word
  wire logic [31:0] next_rd_b = (i_rd_b_idx == `MBRF_IDX_R15) ?
    combined_counter_status_register :
    regs[ph_b];

  // register storage; link beats the general port on clash
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      for (int k = 0; k < `MBRF_NPHYS; k++) begin
        regs[k] <= `MBRF_WORD_ZERO;
      end
    end else if (exc_go) begin
      regs[ph_x] <= combined_counter_status_register;
    end else begin
      if (wr_gen) begin
        regs[ph_w] <= i_wr_data;
      end
      if (link_go) begin
        regs[ph_l] <= link_word;
      end
    end
  end

  // counter and status; reset lands in supervisor, masked
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      program_counter <= `MBRF_PC_RST;
      processor_status_bits <= `MBRF_ST_RST;
    end else begin
      program_counter <= next_pc;
      processor_status_bits <= next_status;
    end
  end

  // output flops
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_rd_a_data <= `MBRF_WORD_ZERO;
      o_rd_b_data <= `MBRF_WORD_ZERO;
      o_fetch_addr <= {`MBRF_PC_RST, `MBRF_ALIGN_ZERO};
      o_status <= `MBRF_ST_RST;
      o_mode <= mbrf_pkg::MBRF_SVC;
      o_exc_taken <= 1'h0;
    end else begin
      o_rd_a_data <= next_rd_a;
      o_rd_b_data <= next_rd_b;
      o_fetch_addr <= {next_pc, `MBRF_ALIGN_ZERO};
      o_status <= next_status;
      o_mode <= next_status[`MBRF_ST_MODE];
      o_exc_taken <= exc_go;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // an accepted exception request
  sequence exc_entry_s;
    exc_go;
  endsequence
  // a status write with no exception competing
  sequence status_write_s;
    i_stat_wr && !exc_go;
  endsequence
  // an abort or undefined instruction accepted
  sequence abort_entry_s;
    exc_go && !fiq_kind && !irq_kind &&
    (i_exc_kind != mbrf_pkg::MBRF_EXC_SWI);
  endsequence

  // reset state seen at the first edge where reset is sampled released
  reset_state_a: assert property (
    @(posedge i_sys_clk) $rose(i_rst_b) |->
      o_mode == 2'h3 && o_status[3:2] == 2'h3 &&
      o_fetch_addr == 26'h0000000)
    else $error("reset state wrong");

  // aborts and undefined land in supervisor
  abort_to_svc_a: assert property (
    abort_entry_s |=> o_mode == 2'h3 && mode == mbrf_pkg::MBRF_SVC)
    else $error("abort did not enter supervisor");

  // entry saves the whole combined word in banked 14
  exc_link_save_a: assert property (
    exc_entry_s |=> regs[$past(ph_x)] ==
      $past(combined_counter_status_register) && o_exc_taken)
    else $error("entry link value wrong");

  // application mode keeps its mode on a status write
  user_mode_hold_a: assert property (
    (mode == mbrf_pkg::MBRF_USR) and status_write_s |=>
      o_mode == 2'h0 && $stable(processor_status_bits[3:0]))
    else $error("user changed mode");

  // privileged status write adopts masks and mode
  priv_ctl_write_a: assert property (
    privileged and status_write_s |=>
      o_status == {$past(i_stat_data[31:26]), $past(i_stat_data[1:0])})
    else $error("status write not adopted");

  // flags follow a flag update in any mode
  flags_update_a: assert property (
    i_flags_wr && !i_stat_wr && !exc_go |=>
      o_status[7:4] == $past(i_flags) && $stable(o_mode))
    else $error("flag update lost");

  // fetch address is the counter with zero low bits
  fetch_align_a: assert property (
    i_pc_wr && !exc_go |=>
      o_fetch_addr == {$past(i_pc_data), 2'h0} &&
      o_fetch_addr[1:0] == 2'h0)
    else $error("fetch address wrong");

  // first operand hides the status bits of register 15
  op_a_hide_a: assert property (
    i_rd_a_idx == 4'hF |=>
      o_rd_a_data[31:26] == 6'h00 && o_rd_a_data[1:0] == 2'h0 &&
      o_rd_a_data[25:2] == $past(program_counter))
    else $error("operand status not hidden");

  // branch-with-link stores counter and status in 14
  branch_link_a: assert property (
    link_go |=> regs[$past(ph_l)] == $past(link_word) &&
      regs[$past(ph_l)][25:2] == $past(i_link_pc))
    else $error("link value wrong");

  // fast mode register 8 lives in its own slot
  fiq_bank_a: assert property (
    mode == mbrf_pkg::MBRF_FIQ && i_rd_b_idx == 4'h8 |=>
      o_rd_b_data == $past(regs[5'h0F]))
    else $error("fast bank miss");

  // interrupt and supervisor 13 read their own slots
  irq_svc_bank_a: assert property (
    privileged && !fiq_kind && i_rd_b_idx == 4'hD &&
    mode != mbrf_pkg::MBRF_FIQ |=>
      o_rd_b_data == $past(regs[(mode == mbrf_pkg::MBRF_IRQ) ?
        5'h16 : 5'h18]))
    else $error("banked 13 miss");

endmodule // mbrf_regfile

//--- test/mbrf_core_model.sv
// core datapath model that issues one request per call to the file
// assumes a free-running i_sys_clk; requests change on the falling edge
module mbrf_core_model (
  // clock
  input wire logic i_sys_clk,
  // read and write requests
  output logic [3:0] o_rd_a_idx,
  output logic [3:0] o_rd_b_idx,
  output logic o_wr_en,
  output logic [3:0] o_wr_idx,
  output logic [31:0] o_wr_data,
  // counter, flags, status and link
  output logic o_pc_wr,
  output logic [23:0] o_pc_data,
  output logic o_flags_wr,
  output logic [3:0] o_flags,
  output logic o_stat_wr,
  output logic [31:0] o_stat_data,
  output logic o_link_wr,
  output logic [23:0] o_link_pc,
  // exception request
  output logic o_exc_req,
  output mbrf_pkg::mbrf_exc_e o_exc_kind,
  output logic [23:0] o_exc_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet request lines from time zero
  initial begin
    {o_rd_a_idx, o_rd_b_idx, o_wr_idx, o_flags} = '0;
    {o_wr_en, o_pc_wr, o_flags_wr, o_stat_wr, o_link_wr, o_exc_req} = '0;
    {o_wr_data, o_stat_data} = '0;
    {o_pc_data, o_link_pc, o_exc_vec} = '0;
    o_exc_kind = mbrf_pkg::MBRF_EXC_FIQ;
  end
  // one request held for exactly one rising edge
  task automatic op(input int k, input logic [31:0] d,
                    input logic [3:0] x);
    @(negedge i_sys_clk);
    case (k)
      0: begin o_wr_en = 1'h1; o_wr_idx = x; o_wr_data = d; end
      1: begin o_stat_wr = 1'h1; o_stat_data = d; end
      2: begin o_flags_wr = 1'h1; o_flags = d[3:0]; end
      3: begin o_pc_wr = 1'h1; o_pc_data = d[23:0]; end
      4: begin o_link_wr = 1'h1; o_link_pc = d[23:0]; end
      5: begin
        o_exc_req = 1'h1;
        o_exc_kind = mbrf_pkg::mbrf_exc_e'(x[2:0]);
        o_exc_vec = d[23:0];
      end
      // read indices only, no strobe
      default: begin o_rd_a_idx = x; o_rd_b_idx = d[3:0]; end
    endcase
    @(negedge i_sys_clk);
    // release strobes; stale write and status data flip so nothing relies on them
    {o_wr_en, o_pc_wr, o_flags_wr, o_stat_wr, o_link_wr, o_exc_req} = '0;
    o_wr_data = ~o_wr_data;
    o_stat_data = ~o_stat_data;
  endtask
endmodule // mbrf_core_model

//--- test/mbrf_regfile_test.sv
// self-checking bench for the mode-banked register file
// assumes the core model drives every request input of the block
module mbrf_regfile_test;
  timeunit 1ns;
  timeprecision 1ps;
  // request kinds understood by the core model
  localparam int K_WR = 0, K_ST = 1, K_FL = 2, K_PC = 3, K_LK = 4;
  localparam int K_EX = 5, K_RD = 6;
  logic i_sys_clk, i_rst_b, wr_en, pc_wr, flags_wr, stat_wr, link_wr;
  logic exc_req, o_exc_taken;
  logic [3:0] rd_a_idx, rd_b_idx, wr_idx, flags;
  logic [31:0] wr_data, stat_data, o_rd_a_data, o_rd_b_data;
  logic [23:0] pc_data, link_pc, exc_vec, pcv;
  mbrf_pkg::mbrf_exc_e exc_kind;
  logic [25:0] o_fetch_addr;
  logic [7:0] o_status;
  logic [1:0] o_mode;
  int error_cnt, compares;
  // 40 MHz clock
  initial begin
    i_sys_clk = 1'h0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  mbrf_core_model u_core (.i_sys_clk(i_sys_clk), .o_rd_a_idx(rd_a_idx),
    .o_rd_b_idx(rd_b_idx), .o_wr_en(wr_en), .o_wr_idx(wr_idx),
    .o_wr_data(wr_data), .o_pc_wr(pc_wr), .o_pc_data(pc_data),
    .o_flags_wr(flags_wr), .o_flags(flags), .o_stat_wr(stat_wr),
    .o_stat_data(stat_data), .o_link_wr(link_wr), .o_link_pc(link_pc),
    .o_exc_req(exc_req), .o_exc_kind(exc_kind), .o_exc_vec(exc_vec));
  mbrf_regfile u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_rd_a_idx(rd_a_idx), .i_rd_b_idx(rd_b_idx), .i_wr_en(wr_en),
    .i_wr_idx(wr_idx), .i_wr_data(wr_data), .i_pc_wr(pc_wr),
    .i_pc_data(pc_data), .i_flags_wr(flags_wr), .i_flags(flags),
    .i_stat_wr(stat_wr), .i_stat_data(stat_data), .i_link_wr(link_wr),
    .i_link_pc(link_pc), .i_exc_req(exc_req), .i_exc_kind(exc_kind),
    .i_exc_vec(exc_vec), .o_rd_a_data(o_rd_a_data),
    .o_rd_b_data(o_rd_b_data), .o_fetch_addr(o_fetch_addr),
    .o_status(o_status), .o_mode(o_mode), .o_exc_taken(o_exc_taken));
  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // combined counter and status word
  function automatic logic [31:0] comb(input logic [7:0] s,
                                      input logic [23:0] p);
    return {s[7:2], p, s[1:0]};
  endfunction
  // read two registers, judge both operands
  task automatic rd(input logic [3:0] a, input logic [3:0] b,
                    input logic [31:0] ea, input logic [31:0] eb);
    u_core.op(K_RD, 32'(b), a);
    chk(o_rd_a_data, ea);
    chk(o_rd_b_data, eb);
  endtask
  // status word write then check of the status byte
  task automatic st(input logic [31:0] d, input logic [7:0] e);
    u_core.op(K_ST, d, 4'h0);
    chk(32'(o_status), 32'(e));
    chk(32'(o_mode), 32'(e[1:0]));
  endtask
  // banked views of 8 and 13 in fast and interrupt mode, 13 and 14 in supervisor
  task automatic t_bank();
    u_core.op(K_WR, 32'hA0000013, 4'hD);
    u_core.op(K_WR, 32'hA0000008, 4'h8);
    u_core.op(K_WR, 32'hA0000014, 4'hE);
    st(32'h0C000001, 8'h0D);
    u_core.op(K_WR, 32'hB0000008, 4'h8);
    u_core.op(K_WR, 32'hB0000013, 4'hD);
    rd(4'h8, 4'hD, 32'hB0000008, 32'hB0000013);
    st(32'h0C000002, 8'h0E);
    rd(4'h8, 4'hD, 32'hA0000008, 32'h00000000);
    u_core.op(K_WR, 32'hC0000013, 4'hD);
    st(32'h0C000003, 8'h0F);
    rd(4'hD, 4'hE, 32'hA0000013, 32'hA0000014);
    $display("bank test done");
  endtask
  // application mode cannot touch masks or mode, flags still move
  task automatic t_user();
    st(32'h00000000, 8'h00);
    st(32'h5C000003, 8'h50);
    u_core.op(K_FL, 32'h0000000A, 4'h0);
    chk(32'(o_status), 32'h000000A0);
    u_core.op(K_WR, 32'hD0000013, 4'hD);
    rd(4'hD, 4'h8, 32'hD0000013, 32'hA0000008);
    $display("user test done");
  endtask
  // counter limits, operand views and link capture
  task automatic t_pc();
    u_core.op(K_PC, 32'h00FFFFFF, 4'h0);
    chk(32'(o_fetch_addr), 32'h03FFFFFC);
    rd(4'hF, 4'hF, 32'h03FFFFFC, comb(8'hA0, 24'hFFFFFF));
    u_core.op(K_WR, 32'h00001235, 4'hF);
    chk(32'(o_fetch_addr), 32'h00001234);
    u_core.op(K_LK, 32'h00000123, 4'h0);
    rd(4'hE, 4'hF, comb(8'hA0, 24'h000123), comb(8'hA0, 24'h00048D));
    $display("counter test done");
  endtask
  // exception entry: save, vector, mode and masking
  task automatic t_exc();
    mbrf_pkg::mbrf_exc_e kinds [5];
    logic [1:0] m;
    kinds = '{mbrf_pkg::MBRF_EXC_FIQ, mbrf_pkg::MBRF_EXC_SWI,
      mbrf_pkg::MBRF_EXC_PABT, mbrf_pkg::MBRF_EXC_DABT,
      mbrf_pkg::MBRF_EXC_UND};
    u_core.op(K_EX, 32'h00000006, {1'h0, mbrf_pkg::MBRF_EXC_IRQ});
    chk(32'(o_exc_taken), 32'h00000001);
    chk(32'(o_status), 32'h000000AA);
    rd(4'hE, 4'hF, comb(8'hA0, 24'h00048D), comb(8'hAA, 24'h000006));
    u_core.op(K_EX, 32'h00000009, {1'h0, mbrf_pkg::MBRF_EXC_IRQ});
    chk(32'({o_exc_taken, o_mode}), 32'h00000002);
    pcv = 24'h000006;
    for (int i = 0; i < 5; i++) begin
      st(32'hA0000000, 8'hA0);
      m = (i == 0) ? 2'h1 : 2'h3;
      u_core.op(K_EX, 32'(24'h000010 + i), {1'h0, kinds[i]});
      chk(32'(o_status), 32'({4'hA, 1'h1, i == 0, m}));
      chk(32'(o_fetch_addr), 32'({24'h000010 + i, 2'h0}));
      rd(4'hE, 4'h0, comb(8'hA0, pcv), 32'h00000000);
      pcv = 24'h000010 + i;
    end
    $display("exception test done");
  endtask
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // bounded run time
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    error_cnt++;
    give_verdict();
  end
  // main sequence
  initial begin
    error_cnt = 0;
    compares = 0;
    i_rst_b = 1'h0;
    repeat (10) @(negedge i_sys_clk);
    chk(32'({o_mode, o_status}), 32'h0000030F);
    chk(32'({o_exc_taken, o_fetch_addr}), 32'h00000000);
    i_rst_b = 1'h1;
    t_bank();
    t_user();
    t_pc();
    t_exc();
    give_verdict();
  end
endmodule // mbrf_regfile_test
